// >>> dv/disp_cmd_monitor.sv
// Checker for the display command decoder ports
`timescale 1ns/1ps
module disp_cmd_monitor #(
    parameter int PIX_W = 18
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic write_strobe_n,
    input wire logic data_command_select,
    input wire logic [7:0] bus_data,
    input wire logic [7:0] memory_access_control,
    input wire logic [PIX_W-1:0] mem_pixel,
    input wire logic mem_pixel_valid,
    input wire logic [PIX_W-1:0] panel_pixel,
    input wire logic panel_pixel_valid,
    input wire logic normal_mode,
    input wire logic partial_mode,
    input wire logic inversion_mode,
    input wire logic display_on,
    input wire logic [15:0] column_start,
    input wire logic [15:0] column_end,
    input wire logic [15:0] write_col_start,
    input wire logic [15:0] write_col_end,
    input wire logic write_window_load,
    input wire logic write_col_in_range
);
    // ----------------------------------------
    // Command history
    // ----------------------------------------
    // Three deep so the exact output latency need not be assumed
    logic strobe_r;
    logic [2:0] tk_r;
    logic [7:0] cd_r [3];
    logic [15:0] lim;
    assign lim = memory_access_control[5] ? 16'h013F : 16'h00EF;
    always_ff @(posedge core_clk) begin
        strobe_r <= write_strobe_n;
        tk_r <= {tk_r[1:0], write_strobe_n & ~strobe_r & ~data_command_select};
        cd_r <= '{bus_data, cd_r[0], cd_r[1]};
    end
    function automatic logic hit(input logic [7:0] c);
        return (tk_r[0] && cd_r[0] == c) || (tk_r[1] && cd_r[1] == c) || (tk_r[2] && cd_r[2] == c);
    endfunction : hit
    sequence s_cmd(logic [7:0] c);
        tk_r[0] && cd_r[0] == c;
    endsequence
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // normal is the inverse of partial
    AST_NORMAL_INV: assert property (normal_mode == !partial_mode)
        else $error("normal flag not inverse of partial flag");
    AST_RESET_DEFAULT: assert property ($fell(rst) |-> normal_mode && !inversion_mode && !display_on
        && column_start == 16'h0000 && column_end == 16'h00EF) else $error("reset defaults wrong");
    AST_INV_SET: assert property (s_cmd(8'h21) |-> ##[0:2] inversion_mode)
        else $error("inversion not entered");
    AST_INV_CLEAR: assert property ($fell(inversion_mode) |-> hit(8'h20) || hit(8'h01))
        else $error("inversion left without its command");
    AST_PARTIAL_CHANGE: assert property ($changed(partial_mode)
        |-> (partial_mode ? hit(8'h12) : (hit(8'h13) || hit(8'h01)))) else $error("partial flag moved");
    AST_DISPLAY_SET: assert property ($rose(display_on) |-> hit(8'h29))
        else $error("display on without its command");
    AST_PIX_VALID: assert property (panel_pixel_valid == $past(mem_pixel_valid && display_on))
        else $error("pixel valid wrong");
    AST_PIX_DATA: assert property (panel_pixel_valid
        |-> panel_pixel == ($past(inversion_mode) ? ~$past(mem_pixel) : $past(mem_pixel)))
        else $error("pixel data wrong");
    AST_LOAD_COPY: assert property (write_window_load
        |-> write_col_start == column_start && write_col_end == column_end) else $error("window copy wrong");
    AST_LOAD_PULSE: assert property (write_window_load |=> !write_window_load)
        else $error("load pulse too long");
    AST_RANGE: assert property (write_window_load
        |-> write_col_in_range == (write_col_start <= lim && write_col_end <= lim)) else $error("range flag wrong");
endmodule : disp_cmd_monitor

// >>> dv/display_mode_column_window_cmds_test.sv
// Testbench: random command stream against a behavioural model
`timescale 1ns/1ps
module display_mode_column_window_cmds_test;
    localparam int PIX_W = 18;
    logic core_clk, rst, write_strobe_n, data_command_select, mem_pixel_valid, panel_pixel_valid;
    logic normal_mode, partial_mode, inversion_mode, display_on, write_window_load, write_col_in_range;
    logic [7:0] bus_data, memory_access_control;
    logic [PIX_W-1:0] mem_pixel, panel_pixel;
    logic [15:0] column_start, column_end, write_col_start, write_col_end;
    logic [7:0] codes [10] = '{8'h12, 8'h13, 8'h20, 8'h21, 8'h28, 8'h29, 8'h2A, 8'h2C, 8'h01, 8'h55};
    int mismatches, checked, m_part, m_inv, m_disp, m_cs, m_ce, m_wcs, m_wce, m_wr, m_wok, m_idx, m_hi;
    display_mode_column_window_cmds #(.PIX_W(PIX_W)) u_dut (.*);
    host_model u_host (.*);
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask : cmp
    task automatic check_all();
        logic [PIX_W-1:0] p;
        logic [PIX_W-1:0] q;
        logic v;
        p = PIX_W'($urandom);
        v = 1'($urandom);
        mem_pixel = p;
        mem_pixel_valid = v;
        q = m_inv ? ~p : p;
        @(negedge core_clk);
        cmp("partial", partial_mode, m_part);
        cmp("normal", normal_mode, !m_part);
        cmp("inversion", inversion_mode, m_inv);
        cmp("display", display_on, m_disp);
        cmp("start", column_start, m_cs);
        cmp("end", column_end, m_ce);
        cmp("valid", panel_pixel_valid, v & m_disp[0]);
        if (m_disp && v) cmp("pixel", panel_pixel, q);
        if (m_wok) begin
            cmp("wstart", write_col_start, m_wcs);
            cmp("wend", write_col_end, m_wce);
            cmp("range", write_col_in_range, m_wr);
        end
    endtask : check_all
    task automatic put(input logic dcs, input logic [7:0] d);
        int lim;
        lim = memory_access_control[5] ? 'h13F : 'hEF;
        u_host.send(dcs, d);
        if (!dcs) begin
            m_idx = (d == 8'h2A);
            case (d)
                8'h12: m_part = 1;
                8'h13: m_part = 0;
                8'h20: m_inv = 0;
                8'h21: m_inv = 1;
                8'h28: m_disp = 0;
                8'h29: m_disp = 1;
                8'h2C: {m_wcs, m_wce, m_wr, m_wok} = {m_cs, m_ce, int'(m_cs <= lim && m_ce <= lim), 1};
                // soft reset end by bit 5
                8'h01: {m_part, m_inv, m_disp, m_cs, m_ce, m_wok} = {0, 0, 0, 0, lim, 0};
                default: ;
            endcase
        end else if (m_idx > 0) begin
            if (m_idx % 2 == 1) m_hi = d;
            else if (m_idx == 2) m_cs = m_hi * 256 + d;
            else m_ce = m_hi * 256 + d;
            m_idx = (m_idx == 4) ? 0 : m_idx + 1;
        end
        check_all();
    endtask : put
    task automatic summarize();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (40000) @(posedge core_clk);
        mismatches++;
        summarize();
    end
    initial begin
        int r, n, s, e;
        {mismatches, checked} = '0;
        rst = 1'b1;
        memory_access_control = 8'h00;
        mem_pixel = '0;
        mem_pixel_valid = 1'b0;
        void'($urandom(27));
        for (int k = 0; k < 2; k++) begin
            rst = 1'b1;
            repeat (4) @(negedge core_clk);
            rst = 1'b0;
            {m_part, m_inv, m_disp, m_cs, m_ce, m_idx} = {0, 0, 0, 0, 'hEF, 0};
            {m_wcs, m_wce, m_wr, m_wok} = {0, 'hEF, 1, 1};
            check_all();
            for (int i = 0; i < 150; i++) begin
                r = $urandom % 13;
                if (r < 10) begin
                    put(1'b0, codes[r]);
                    if (r == 6) begin
                        s = $urandom % 'h150;
                        e = s + $urandom % ('h150 - s);
                        n = ($urandom % 5 == 0) ? $urandom % 4 : 4;
                        for (int j = 0; j < n; j++) put(1'b1, 8'(((j < 2) ? s : e) >> ((j % 2 == 0) ? 8 : 0)));
                    end
                end else if (r < 12) put(1'b1, 8'($urandom));
                else memory_access_control = 8'($urandom);
            end
        end
        summarize();
    end
endmodule : display_mode_column_window_cmds_test
bind display_mode_column_window_cmds disp_cmd_monitor #(.PIX_W(PIX_W)) u_mon (.*);

// >>> dv/host_model.sv
// Host side model driving command and parameter bytes
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk,
    output logic write_strobe_n,
    output logic data_command_select,
    output logic [7:0] bus_data
);
    initial begin
        write_strobe_n = 1'b1;
        data_command_select = 1'b0;
        bus_data = 8'hFF;
    end
    task automatic send(input logic dcs, input logic [7:0] d);
        @(negedge core_clk);
        data_command_select = dcs;
        bus_data = d;
        write_strobe_n = 1'b0;
        @(negedge core_clk);
        write_strobe_n = 1'b1;
        @(negedge core_clk);
        // Released bus shows the inverse so stale data cannot match
        bus_data = ~d;
        data_command_select = ~dcs;
        repeat (3) @(negedge core_clk);
    endtask : send
endmodule : host_model

// >>> inc/disp_cmd_pkg.sv
// Package: command codes, reset values and carrier types for the display command decoder
package disp_cmd_pkg;
    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] PARTIAL_ON_CMD = 8'h12;
    localparam logic [7:0] NORMAL_DISPLAY_CMD = 8'h13;
    localparam logic [7:0] INVERSION_OFF_CMD = 8'h20;
    localparam logic [7:0] INVERSION_ON_CMD = 8'h21;
    localparam logic [7:0] DISPLAY_OFF_CMD = 8'h28;
    localparam logic [7:0] DISPLAY_ON_CMD = 8'h29;
    localparam logic [7:0] COLUMN_WINDOW_CMD = 8'h2A;
    localparam logic [7:0] MEMORY_WRITE_CMD = 8'h2C;
    localparam logic [7:0] SW_RESET_CMD = 8'h01;
    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [15:0] COL_START_RST = 16'h0000;
    localparam logic [15:0] COL_LIMIT_NARROW = 16'h00EF;
    localparam logic [15:0] COL_LIMIT_WIDE = 16'h013F;
    localparam int MAC_WIDE_BIT = 5;
    localparam int PARAM_COUNT = 4;
    // ----------------------------------------
    // Carrier types
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic is_param;
    } host_byte_t;
    typedef struct packed {
        logic [15:0] start;
        logic [15:0] stop;
    } col_window_t;
    typedef struct packed {
        logic partial;
        logic inverted;
        logic display_on;
    } mode_flags_t;
endpackage : disp_cmd_pkg

// >>> rtl/display_mode_column_window_cmds.sv
// Command decoder: display modes and column window for the panel driver
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
module display_mode_column_window_cmds #(
    parameter int PIX_W = 18
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic write_strobe_n,
    input wire logic data_command_select,
    input wire logic [7:0] bus_data,
    input wire logic [7:0] memory_access_control,
    input wire logic [PIX_W-1:0] mem_pixel,
    input wire logic mem_pixel_valid,
    output logic [PIX_W-1:0] panel_pixel,
    output logic panel_pixel_valid,
    output logic normal_mode,
    output logic partial_mode,
    output logic inversion_mode,
    output logic display_on,
    output logic [15:0] column_start,
    output logic [15:0] column_end,
    output logic [15:0] write_col_start,
    output logic [15:0] write_col_end,
    output logic write_window_load,
    output logic write_col_in_range
);
    // ----------------------------------------
    // Parameter collection states
    // ----------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SH = 5'b00010,
        ST_SL = 5'b00100,
        ST_EH = 5'b01000,
        ST_EL = 5'b10000
    } col_state_t;

    col_state_t state_r;
    col_state_t state_nxt;
    disp_cmd_pkg::host_byte_t hb;
    logic hb_valid;
    disp_cmd_pkg::mode_flags_t flags_r;
    disp_cmd_pkg::mode_flags_t flags_nxt;
    disp_cmd_pkg::col_window_t win_r;
    disp_cmd_pkg::col_window_t win_nxt;
    logic [7:0] hold_r;
    logic [7:0] hold_nxt;

    // ----------------------------------------
    // Byte capture
    // ----------------------------------------
    // Strobe edge capture
    strobe_capture u_capture (
        .core_clk(core_clk),
        .rst(rst),
        .write_strobe_n(write_strobe_n),
        .data_command_select(data_command_select),
        .bus_data(bus_data),
        .byte_out(hb),
        .byte_valid(hb_valid)
    );

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic is_cmd(input disp_cmd_pkg::host_byte_t b, input logic v, input logic [7:0] code);
        is_cmd = v & ~b.is_param & (b.data == code);
    endfunction : is_cmd

    wire cmd_w = hb_valid & ~hb.is_param;
    wire param_w = hb_valid & hb.is_param;
    wire cmd_partial_w = is_cmd(hb, hb_valid, disp_cmd_pkg::PARTIAL_ON_CMD);
    wire cmd_normal_w = is_cmd(hb, hb_valid, disp_cmd_pkg::NORMAL_DISPLAY_CMD);
    wire cmd_inv_off_w = is_cmd(hb, hb_valid, disp_cmd_pkg::INVERSION_OFF_CMD);
    wire cmd_inv_on_w = is_cmd(hb, hb_valid, disp_cmd_pkg::INVERSION_ON_CMD);
    wire cmd_disp_off_w = is_cmd(hb, hb_valid, disp_cmd_pkg::DISPLAY_OFF_CMD);
    wire cmd_disp_on_w = is_cmd(hb, hb_valid, disp_cmd_pkg::DISPLAY_ON_CMD);
    wire cmd_col_w = is_cmd(hb, hb_valid, disp_cmd_pkg::COLUMN_WINDOW_CMD);
    wire cmd_memwr_w = is_cmd(hb, hb_valid, disp_cmd_pkg::MEMORY_WRITE_CMD);
    wire cmd_swrst_w = is_cmd(hb, hb_valid, disp_cmd_pkg::SW_RESET_CMD);
    wire wide_w = memory_access_control[disp_cmd_pkg::MAC_WIDE_BIT];
    wire [15:0] limit_w = wide_w ? disp_cmd_pkg::COL_LIMIT_WIDE : disp_cmd_pkg::COL_LIMIT_NARROW;
    wire [15:0] sw_end_w = limit_w;

    // ----------------------------------------
    // Mode flags
    // ----------------------------------------
    always_comb begin
        flags_nxt = flags_r;
        if (cmd_swrst_w) begin
            flags_nxt = '0;
        end else begin
            if (cmd_partial_w) begin
                flags_nxt.partial = 1'b1;
            end
            if (cmd_normal_w) begin
                flags_nxt.partial = 1'b0;
            end
            if (cmd_inv_on_w) begin
                flags_nxt.inverted = 1'b1;
            end
            if (cmd_inv_off_w) begin
                flags_nxt.inverted = 1'b0;
            end
            if (cmd_disp_on_w) begin
                flags_nxt.display_on = 1'b1;
            end
            if (cmd_disp_off_w) begin
                flags_nxt.display_on = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Column window parameter sequence
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        win_nxt = win_r;
        hold_nxt = hold_r;
        if (cmd_swrst_w) begin
            state_nxt = ST_IDLE;
            win_nxt = '{start: disp_cmd_pkg::COL_START_RST, stop: sw_end_w};
        end else if (cmd_w) begin
            state_nxt = cmd_col_w ? ST_SH : ST_IDLE;
        end else if (param_w) begin
            unique case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_IDLE;
                end
                ST_SH: begin
                    hold_nxt = hb.data;
                    state_nxt = ST_SL;
                end
                ST_SL: begin
                    win_nxt.start = {hold_r, hb.data};
                    state_nxt = ST_EH;
                end
                ST_EH: begin
                    hold_nxt = hb.data;
                    state_nxt = ST_EL;
                end
                ST_EL: begin
                    win_nxt.stop = {hold_r, hb.data};
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flags_r <= '0;
            state_r <= ST_IDLE;
            hold_r <= 8'h00;
            win_r <= '{start: disp_cmd_pkg::COL_START_RST, stop: disp_cmd_pkg::COL_LIMIT_NARROW};
        end else begin
            flags_r <= flags_nxt;
            state_r <= state_nxt;
            hold_r <= hold_nxt;
            win_r <= win_nxt;
        end
    end

    // ----------------------------------------
    // Outputs and memory-write window
    // ----------------------------------------
    // Range check uses the live window; the host is trusted to keep start not above end
    // Host ordering assumed
    wire in_range_w = (win_r.start <= limit_w) & (win_r.stop <= limit_w);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            normal_mode <= 1'b1;
            partial_mode <= 1'b0;
            inversion_mode <= 1'b0;
            display_on <= 1'b0;
            column_start <= disp_cmd_pkg::COL_START_RST;
            column_end <= disp_cmd_pkg::COL_LIMIT_NARROW;
            write_col_start <= disp_cmd_pkg::COL_START_RST;
            write_col_end <= disp_cmd_pkg::COL_LIMIT_NARROW;
            write_window_load <= 1'b0;
            write_col_in_range <= 1'b1;
        end else begin
            normal_mode <= ~flags_nxt.partial;
            partial_mode <= flags_nxt.partial;
            inversion_mode <= flags_nxt.inverted;
            display_on <= flags_nxt.display_on;
            column_start <= win_nxt.start;
            column_end <= win_nxt.stop;
            write_window_load <= cmd_memwr_w;
            if (cmd_memwr_w) begin
                write_col_start <= win_r.start;
                write_col_end <= win_r.stop;
                write_col_in_range <= in_range_w;
            end
        end
    end

    // ----------------------------------------
    // Pixel path
    // ----------------------------------------
    // Inversion only on outgoing data
    pixel_path #(
        .PIX_W(PIX_W)
    ) u_pixels (
        .core_clk(core_clk),
        .rst(rst),
        .invert(flags_r.inverted),
        .enable(flags_r.display_on),
        .mem_pixel(mem_pixel),
        .mem_pixel_valid(mem_pixel_valid),
        .panel_pixel(panel_pixel),
        .panel_pixel_valid(panel_pixel_valid)
    );
endmodule : display_mode_column_window_cmds

// >>> rtl/pixel_path.sv
// Pixel path from frame memory to panel with inversion and output enable
`timescale 1ns/1ps
module pixel_path #(
    parameter int PIX_W = 18
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic invert,
    input wire logic enable,
    input wire logic [PIX_W-1:0] mem_pixel,
    input wire logic mem_pixel_valid,
    output logic [PIX_W-1:0] panel_pixel,
    output logic panel_pixel_valid
);
    // Memory content is never touched; only the outgoing copy is inverted
    wire [PIX_W-1:0] shaped_w = invert ? ~mem_pixel : mem_pixel;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            panel_pixel <= '0;
            panel_pixel_valid <= 1'b0;
        end else begin
            panel_pixel_valid <= mem_pixel_valid & enable;
            panel_pixel <= enable ? shaped_w : '0;
        end
    end
endmodule : pixel_path

// >>> rtl/strobe_capture.sv
// Strobe edge detector: turns the write strobe rising edge into a byte pulse
`timescale 1ns/1ps
module strobe_capture (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic write_strobe_n,
    input wire logic data_command_select,
    input wire logic [7:0] bus_data,
    output disp_cmd_pkg::host_byte_t byte_out,
    output logic byte_valid
);
    logic strobe_d_r;
    wire rise_w = write_strobe_n & ~strobe_d_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            strobe_d_r <= 1'b1;
            byte_valid <= 1'b0;
            byte_out <= '0;
        end else begin
            strobe_d_r <= write_strobe_n;
            byte_valid <= rise_w;
            if (rise_w) begin
                byte_out <= '{data: bus_data, is_param: data_command_select};
            end
        end
    end
endmodule : strobe_capture
